// File: debug_host_model.sv
`timescale 1ns/10ps
module debug_host_model (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Link toward the device
  output logic sync_seen,
  output logic bit_tick,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [1:0] tick_reg = 2'h1;
  int ticks = 0;
  int idle_seen;
  bit slow = 1'b0;
  initial begin
    sync_seen = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // One bit time every four cycles
  assign bit_tick = (tick_reg == 2'h0);
  always @(posedge clock) begin
    #1;
    tick_reg <= tick_reg + 2'h1;
  end
  always @(posedge clock) begin
    if (rx_valid) ticks <= 0;
    else if (bit_tick) ticks <= ticks + 1;
  end
  task automatic put_byte(input logic [7:0] b);
    @(posedge clock);
    #1;
    rx_valid = 1'b1;
    rx_data = b;
    @(posedge clock);
    #1;
    rx_valid = 1'b0;
    // Released line must not keep the old byte
    rx_data = ~b;
  endtask : put_byte
  task automatic put_instr(input logic [7:0] op);
    @(posedge clock);
    #1;
    sync_seen = 1'b1;
    @(posedge clock);
    #1;
    sync_seen = 1'b0;
    put_byte(op);
  endtask : put_instr
  // Bounded wait; a slow host lets the buffer fill
  task automatic take_byte(output logic [7:0] b);
    int n;
    n = 0;
    while (tx_valid !== 1'b1 && n < 3000) begin
      @(posedge clock);
      #1;
      n++;
    end
    idle_seen = ticks;
    if (slow) begin
      repeat (6) @(posedge clock);
      #1;
    end
    tx_ready = 1'b1;
    b = (tx_valid === 1'b1) ? tx_data : 8'hxx;
    @(posedge clock);
    #1;
    tx_ready = 1'b0;
  endtask : take_byte
endmodule : debug_host_model

// File: debug_link_memory_access.sv
`timescale 1ns/10ps
module debug_link_memory_access
  import debug_link_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Receive side of the link
  input wire logic sync_seen,
  input wire logic bit_tick,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // Transmit side of the link
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Repeat counter
  input wire logic rpt_load,
  input wire logic [7:0] rpt_value,
  // System bus
  output bus_req_t bus_out,
  input wire bus_rsp_t bus_in,
  // Control space contents
  output logic [CSR_N-1:0][7:0] csr_out
);

  state_t s_reg;
  state_t s_next;

  logic [2:0] op;
  logic [1:0] pm;
  logic [1:0] asz;
  logic [1:0] dsz;
  logic [CSR_AW-1:0] cidx;
  logic [2:0] guard;

  assign op = s_reg.opcode[OP_MSB:OP_LSB];
  assign pm = s_reg.opcode[ASZ_MSB:ASZ_LSB];
  assign asz = s_reg.opcode[ASZ_MSB:ASZ_LSB];
  assign dsz = (op == OP_CREAD || op == OP_CWRITE) ? 2'h0 : s_reg.opcode[SZ_MSB:SZ_LSB];
  assign cidx = s_reg.opcode[CSR_AW-1:0];
  assign guard = s_reg.csr[CSR_GUARD_IDX][GUARD_MSB:0];

  always_comb begin
    logic [7:0] opc;
    logic [2:0] o;
    logic [1:0] m;
    logic restart;
    logic push;
    byte_t pbyte;
    opc = s_reg.opcode;
    o = 3'h0;
    m = 2'h0;
    restart = 1'b0;
    push = 1'b0;
    pbyte = '0;
    s_next = s_reg;
    if (sync_seen) begin
      s_next.armed = 1'b1;
    end
    if (rpt_load) begin
      s_next.rpt = rpt_value;
    end
    // Pop drains head; tail moves up so no word is lost while stalled
    if (s_reg.head.valid && tx_ready) begin
      s_next.head = s_reg.tail;
      s_next.tail = '0;
    end
    case (s_reg.phase)
      PH_IDLE: begin
        if (rx_valid && s_reg.armed) begin
          opc = rx_data;
          s_next.opcode = rx_data;
          s_next.armed = sync_seen;
          s_next.iter = s_reg.rpt;
          s_next.rpt = rpt_load ? rpt_value : 8'h00;
          s_next.wstage = 1'b0;
          s_next.turn = 1'b1;
          restart = 1'b1;
        end
      end
      PH_ADDR: begin
        if (rx_valid) begin
          s_next.addr[8*s_reg.cnt +: 8] = rx_data;
          s_next.turn = 1'b1;
          s_next.gcnt = 3'h0;
          if ((op == OP_PWRITE) ? (s_reg.cnt == dsz) : (s_reg.cnt == asz)) begin
            s_next.cnt = 2'h0;
            if (op == OP_PWRITE) begin
              s_next.ptr = s_next.addr;
              s_next.data = {24'h000000, ACK_BYTE};
              s_next.slen = 2'h0;
              s_next.phase = PH_GUARD;
            end else if (op == OP_DWRITE) begin
              s_next.data = {24'h000000, ACK_BYTE};
              s_next.slen = 2'h0;
              s_next.phase = PH_GUARD;
            end else begin
              s_next.bus.req = 1'b1;
              s_next.bus.we = 1'b0;
              s_next.bus.addr = s_next.addr;
              s_next.bus.size = dsz;
              s_next.phase = PH_BUS;
            end
          end else begin
            s_next.cnt = s_reg.cnt + 2'h1;
          end
        end
      end
      PH_DATA: begin
        if (rx_valid) begin
          s_next.data[8*s_reg.cnt +: 8] = rx_data;
          s_next.turn = 1'b1;
          s_next.gcnt = 3'h0;
          if (s_reg.cnt == dsz) begin
            s_next.cnt = 2'h0;
            if (op == OP_CWRITE) begin
              s_next.csr[cidx] = rx_data;
              restart = s_reg.iter != 8'h00;
              s_next.iter = s_reg.iter - 8'h01;
              s_next.phase = PH_IDLE;
            end else begin
              s_next.bus.req = 1'b1;
              s_next.bus.we = 1'b1;
              s_next.bus.addr = (op == OP_PWRITE) ? s_reg.ptr : s_reg.addr;
              s_next.bus.wdata = s_next.data;
              s_next.bus.size = dsz;
              s_next.phase = PH_BUS;
            end
          end else begin
            s_next.cnt = s_reg.cnt + 2'h1;
          end
        end
      end
      PH_BUS: begin
        // Request stays up until the far side answers
        if (bus_in.ack) begin
          s_next.bus.req = 1'b0;
          if (bus_in.err) begin
            // No answer on failure; recovery is handled outside
            s_next.phase = PH_IDLE;
            s_next.iter = 8'h00;
          end else begin
            if (s_reg.bus.we) begin
              s_next.data = {24'h000000, ACK_BYTE};
              s_next.slen = 2'h0;
            end else begin
              s_next.data = bus_in.rdata;
              s_next.slen = dsz;
            end
            if ((op == OP_PREAD || op == OP_PWRITE) && pm == PM_INC) begin
              s_next.ptr = s_reg.ptr + ADDR_W'({dsz} + 3'h1);
            end
            s_next.phase = PH_GUARD;
          end
        end
      end
      PH_GUARD: begin
        // Idle bits only after a receive; streamed reads skip them
        if (!s_reg.turn || s_reg.gcnt == guard) begin
          s_next.turn = 1'b0;
          s_next.gcnt = 3'h0;
          s_next.phase = PH_SEND;
        end else if (bit_tick) begin
          s_next.gcnt = s_reg.gcnt + 3'h1;
        end
      end
      PH_SEND: begin
        if (!s_reg.tail.valid) begin
          push = 1'b1;
          pbyte.valid = 1'b1;
          pbyte.data = s_reg.data[8*s_reg.cnt +: 8];
          if (s_reg.cnt == s_reg.slen) begin
            s_next.cnt = 2'h0;
            if (op == OP_DWRITE && !s_reg.wstage) begin
              s_next.wstage = 1'b1;
              s_next.phase = PH_DATA;
            end else begin
              restart = s_reg.iter != 8'h00;
              s_next.iter = s_reg.iter - 8'h01;
              s_next.wstage = 1'b0;
              s_next.phase = PH_IDLE;
            end
          end else begin
            s_next.cnt = s_reg.cnt + 2'h1;
          end
        end
      end
      default: begin
        s_next.phase = PH_IDLE;
      end
    endcase
    if (restart) begin
      o = opc[OP_MSB:OP_LSB];
      m = opc[ASZ_MSB:ASZ_LSB];
      s_next.cnt = 2'h0;
      s_next.gcnt = 3'h0;
      // Stale upper bytes must not leak into short operands
      s_next.addr = '0;
      s_next.data = '0;
      case (o)
        OP_DREAD, OP_DWRITE: begin
          s_next.phase = PH_ADDR;
        end
        OP_PREAD: begin
          if (m == PM_PTR) begin
            s_next.data = s_reg.ptr;
            s_next.slen = opc[SZ_MSB:SZ_LSB];
            s_next.phase = PH_GUARD;
          end else if (m == PM_PLAIN || m == PM_INC) begin
            s_next.bus.req = 1'b1;
            s_next.bus.we = 1'b0;
            s_next.bus.addr = s_next.ptr;
            s_next.bus.size = opc[SZ_MSB:SZ_LSB];
            s_next.phase = PH_BUS;
          end else begin
            s_next.phase = PH_IDLE;
            s_next.iter = 8'h00;
          end
        end
        OP_PWRITE: begin
          if (m == PM_PTR) begin
            s_next.phase = PH_ADDR;
          end else if (m == PM_PLAIN || m == PM_INC) begin
            s_next.phase = PH_DATA;
          end else begin
            s_next.phase = PH_IDLE;
            s_next.iter = 8'h00;
          end
        end
        OP_CREAD: begin
          s_next.data = {24'h000000, s_next.csr[opc[CSR_AW-1:0]]};
          s_next.slen = 2'h0;
          s_next.phase = PH_GUARD;
        end
        OP_CWRITE: begin
          s_next.phase = PH_DATA;
        end
        default: begin
          s_next.phase = PH_IDLE;
          s_next.iter = 8'h00;
        end
      endcase
    end
    if (push) begin
      if (!s_next.head.valid) begin
        s_next.head = pbyte;
      end else begin
        s_next.tail = pbyte;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '0;
      for (int i = 0; i < CSR_N; i++) begin
        s_reg.csr[i] <= CSR_RESET;
      end
    end else begin
      s_reg <= s_next;
    end
  end

  assign tx_valid = s_reg.head.valid;
  assign tx_data = s_reg.head.data;
  assign bus_out = s_reg.bus;
  assign csr_out = s_reg.csr;

  sequence s_bus_wait;
    s_reg.bus.req && !bus_in.ack;
  endsequence

  sequence s_start_bad_pm;
    s_reg.phase == PH_IDLE && rx_valid && s_reg.armed && rx_data[ASZ_MSB:ASZ_LSB] == 2'h3 &&
      (rx_data[OP_MSB:OP_LSB] == OP_PREAD || rx_data[OP_MSB:OP_LSB] == OP_PWRITE);
  endsequence

  sequence s_write_done;
    s_reg.phase == PH_BUS && bus_in.ack && !bus_in.err && s_reg.bus.we;
  endsequence

  AST_REQ_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
    s_bus_wait |=> s_reg.bus.req)
    else $error("bus request dropped before answer");

  AST_BAD_PM: assert property (@(posedge clock) disable iff (sys_rst)
    s_start_bad_pm |=> !s_reg.bus.req && s_reg.phase == PH_IDLE)
    else $error("invalid pointer mode started access");

  AST_WRITE_ACK: assert property (@(posedge clock) disable iff (sys_rst)
    s_write_done |=> s_reg.phase == PH_GUARD && s_reg.data[7:0] == ACK_BYTE && s_reg.slen == 2'h0)
    else $error("no acknowledge queued after bus write");

  AST_GUARD_COUNT: assert property (@(posedge clock) disable iff (sys_rst)
    (s_reg.phase == PH_GUARD && s_reg.turn && s_next.phase == PH_SEND) |-> s_reg.gcnt == guard)
    else $error("response left before idle bits done");

  AST_PTR_INC: assert property (@(posedge clock) disable iff (sys_rst)
    (s_reg.phase == PH_BUS && bus_in.ack && !bus_in.err && op == OP_PWRITE && pm == PM_INC)
      |=> s_reg.ptr == $past(s_reg.ptr) + ADDR_W'({$past(dsz)} + 3'h1))
    else $error("pointer not advanced by data size");

  AST_PTR_KEEP: assert property (@(posedge clock) disable iff (sys_rst)
    (s_reg.phase == PH_BUS && op == OP_PWRITE && pm == PM_PLAIN) |=> $stable(s_reg.ptr))
    else $error("pointer moved in plain mode");

  AST_CSR_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
    (s_reg.phase == PH_DATA && op == OP_CWRITE && rx_valid)
      |=> s_reg.csr[$past(cidx)] == $past(rx_data))
    else $error("control byte not stored");

  AST_ONCE: assert property (@(posedge clock) disable iff (sys_rst)
    (s_reg.phase == PH_IDLE && rx_valid && s_reg.armed && s_reg.rpt == 8'h00) |=> s_reg.iter == 8'h00)
    else $error("zero repeat count not single run");

  AST_READDR: assert property (@(posedge clock) disable iff (sys_rst)
    (s_reg.phase == PH_SEND && op == OP_DREAD && !s_reg.tail.valid && s_reg.cnt == s_reg.slen &&
      s_reg.iter != 8'h00) |=> s_reg.phase == PH_ADDR)
    else $error("repeated direct read skipped address");

  AST_NEED_SYNC: assert property (@(posedge clock) disable iff (sys_rst)
    (s_reg.phase == PH_IDLE && !s_reg.armed) |=> s_reg.phase == PH_IDLE)
    else $error("instruction taken without training char");

endmodule : debug_link_memory_access

// File: debug_link_pkg.sv
// Behaviour
// - Direct read: 32-bit address/data, repeatable
// - Direct read returns data after turnaround idle
// - Repeated direct read takes address each time
// - Read waits on bus handshake latency
// - Direct write: address then data, repeatable
// - Direct write acknowledges address before data
// - Direct write acknowledges again after bus write
// - Pointer read uses pointer, optional post-increment
// - Pointer read may return the pointer itself
// - Pointer commands support 32-bit sizes
// - Pointer read data follows turnaround idle
// - Pointer mode 0x2 loads pointer, then ACK
// - Mode 0x0 keeps pointer, 0x1 advances it
// - Pointer data write acknowledged after bus write
// - Control read: opcode address, one byte only
// - Control read byte follows turnaround idle
// - Control write stores one whole byte
// - Each instruction byte needs preceding training char
// - Idle bits precede first byte after turnaround
// - Repeat count zero runs instruction once
package debug_link_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CSR_N = 16;
  localparam int CSR_AW = 4;

  localparam int OP_MSB = 7;
  localparam int OP_LSB = 5;
  localparam int ASZ_MSB = 3;
  localparam int ASZ_LSB = 2;
  localparam int SZ_MSB = 1;
  localparam int SZ_LSB = 0;
  localparam int CSR_GUARD_IDX = 2;
  localparam int GUARD_MSB = 2;

  localparam logic [2:0] OP_DREAD = 3'h0;
  localparam logic [2:0] OP_PREAD = 3'h1;
  localparam logic [2:0] OP_DWRITE = 3'h2;
  localparam logic [2:0] OP_PWRITE = 3'h3;
  localparam logic [2:0] OP_CREAD = 3'h4;
  localparam logic [2:0] OP_CWRITE = 3'h6;

  localparam logic [1:0] PM_PLAIN = 2'h0;
  localparam logic [1:0] PM_INC = 2'h1;
  localparam logic [1:0] PM_PTR = 2'h2;

  localparam logic [7:0] ACK_BYTE = 8'h40;
  localparam logic [7:0] CSR_RESET = 8'h00;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_ADDR = 3'b001,
    PH_DATA = 3'b010,
    PH_BUS = 3'b011,
    PH_GUARD = 3'b100,
    PH_SEND = 3'b101
  } phase_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] size;
  } bus_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [DATA_W-1:0] rdata;
  } bus_rsp_t;

  typedef struct packed {
    phase_t phase;
    logic armed;
    logic turn;
    logic wstage;
    logic [7:0] opcode;
    logic [1:0] cnt;
    logic [1:0] slen;
    logic [2:0] gcnt;
    logic [7:0] iter;
    logic [7:0] rpt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [ADDR_W-1:0] ptr;
    logic [CSR_N-1:0][7:0] csr;
    byte_t head;
    byte_t tail;
    bus_req_t bus;
  } state_t;

endpackage : debug_link_pkg

// File: test_debug_link_memory_access.sv
`timescale 1ns/10ps
module test_debug_link_memory_access;
  import debug_link_pkg::*;
  logic clock, sys_rst, sync_seen, bit_tick, rx_valid, tx_valid, tx_ready, rpt_load;
  logic [7:0] rx_data, tx_data, rpt_value;
  bus_req_t bus_out;
  bus_rsp_t bus_in = '0;
  logic [CSR_N-1:0][7:0] csr_out;
  logic [1:0] bcnt = 2'h0;
  logic [1:0] last_sz;
  logic [31:0] wa_q[$];
  logic [31:0] wd_q[$];
  int reqs, err_count, comparisons, cyc;
  debug_link_memory_access dut (.clock(clock), .sys_rst(sys_rst), .sync_seen(sync_seen),
    .bit_tick(bit_tick), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rpt_load(rpt_load), .rpt_value(rpt_value),
    .bus_out(bus_out), .bus_in(bus_in), .csr_out(csr_out));
  debug_host_model host (.clock(clock), .sys_rst(sys_rst), .sync_seen(sync_seen),
    .bit_tick(bit_tick), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));
  always #2.5 clock = ~clock;
  function automatic logic [31:0] rd(input logic [31:0] a);
    return {a[15:0] ^ 16'hc3a5, a[15:0]};
  endfunction : rd
  // Bus slave answers after three cycles to expose read latency
  always @(posedge clock) begin
    #1;
    bus_in.ack = 1'b0;
    if (bus_out.req === 1'b1 && bcnt == 2'h2) begin
      bus_in.ack = 1'b1;
      bus_in.rdata = rd(bus_out.addr);
      last_sz = bus_out.size;
      bcnt = 2'h0;
      reqs++;
      if (bus_out.we) begin
        wa_q.push_back(bus_out.addr);
        wd_q.push_back(bus_out.wdata);
      end
    end else begin
      bus_in.rdata = ~rd(bus_out.addr);
      if (bus_out.req === 1'b1) bcnt++;
    end
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic send_n(input int n, input logic [31:0] v);
    for (int i = 0; i < n; i++) host.put_byte(v[8*i +: 8]);
  endtask : send_n
  task automatic recv_n(input int n, input logic [31:0] exp, input string what);
    logic [7:0] b;
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < n; i++) begin
      host.take_byte(b);
      v[8*i +: 8] = b;
    end
    chk(v, exp, what);
  endtask : recv_n
  task automatic expect_wr(input logic [31:0] a, input logic [31:0] d, input logic [31:0] m);
    if (wa_q.size() == 0) chk(32'h0, 32'h1, "bus write missing");
    else begin
      chk(wa_q.pop_front(), a, "write addr");
      chk(wd_q.pop_front() & m, d, "write data");
    end
  endtask : expect_wr
  task automatic set_rpt(input logic [7:0] v);
    @(posedge clock);
    #1;
    rpt_load = 1'b1;
    rpt_value = v;
    @(posedge clock);
    #1;
    rpt_load = 1'b0;
  endtask : set_rpt
  task automatic t_ctrl;
    chk(32'(csr_out[2]), 32'(CSR_RESET), "csr reset");
    host.put_instr({OP_CWRITE, 1'b0, 4'h2});
    host.put_byte(8'h03);
    repeat (4) @(posedge clock);
    chk(32'(csr_out[2]), 32'h03, "csr write");
    host.put_instr({OP_CREAD, 1'b0, 4'h2});
    recv_n(1, 32'h03, "csr read");
    chk(32'(host.idle_seen >= 3), 32'h1, "guard idle");
    $display("ctrl space test done");
  endtask : t_ctrl
  task automatic t_dwrite;
    host.put_instr({OP_DWRITE, 1'b0, 2'h3, 2'h3});
    send_n(4, 32'h0000_1234);
    recv_n(1, 32'(ACK_BYTE), "addr ack");
    send_n(4, 32'hdead_beef);
    recv_n(1, 32'(ACK_BYTE), "data ack");
    expect_wr(32'h1234, 32'hdead_beef, 32'hffff_ffff);
    $display("direct write test done");
  endtask : t_dwrite
  task automatic t_dread;
    set_rpt(8'h01);
    host.put_instr({OP_DREAD, 1'b0, 2'h1, 2'h2});
    for (int i = 2; i < 4; i++) begin
      send_n(2, 32'(i) << 8);
      recv_n(3, rd(32'(i) << 8) & 32'hff_ffff, "direct read");
    end
    chk(32'(last_sz), 32'h2, "read size");
    send_n(2, 32'h0400);
    repeat (200) @(posedge clock);
    chk(32'(tx_valid), 32'h0, "extra iteration");
    $display("direct read test done");
  endtask : t_dread
  task automatic t_pwrite;
    int r0;
    r0 = reqs;
    host.put_instr({OP_PWRITE, 1'b0, PM_PTR, 2'h1});
    send_n(2, 32'h0100);
    recv_n(1, 32'(ACK_BYTE), "ptr ack");
    chk(32'(reqs - r0), 32'h0, "ptr load used bus");
    set_rpt(8'h02);
    host.put_instr({OP_PWRITE, 1'b0, PM_INC, 2'h0});
    for (int i = 0; i < 3; i++) begin
      send_n(1, 32'h10 + i);
      recv_n(1, 32'(ACK_BYTE), "write ack");
      expect_wr(32'h100 + i, 32'h10 + i, 32'hff);
    end
    host.put_instr({OP_PWRITE, 1'b0, PM_PLAIN, 2'h0});
    send_n(1, 32'h77);
    recv_n(1, 32'(ACK_BYTE), "plain ack");
    expect_wr(32'h103, 32'h77, 32'hff);
    $display("pointer write test done");
  endtask : t_pwrite
  task automatic t_pread;
    host.put_instr({OP_PREAD, 1'b0, PM_PTR, 2'h3});
    recv_n(4, 32'h103, "ptr value");
    host.slow = 1'b1;
    set_rpt(8'h02);
    host.put_instr({OP_PREAD, 1'b0, PM_INC, 2'h1});
    for (int i = 0; i < 3; i++) begin
      recv_n(2, rd(32'h103 + 2 * i) & 32'hffff, "ptr read");
    end
    host.slow = 1'b0;
    host.put_instr({OP_PREAD, 1'b0, PM_PTR, 2'h3});
    recv_n(4, 32'h109, "ptr advanced");
    $display("pointer read test done");
  endtask : t_pread
  task automatic t_refuse;
    int r0;
    r0 = reqs;
    host.put_instr({OP_PWRITE, 1'b0, 2'h3, 2'h0});
    send_n(1, 32'h55);
    host.put_instr({OP_PREAD, 1'b0, 2'h3, 2'h0});
    host.put_instr({3'h5, 5'h00});
    repeat (100) @(posedge clock);
    chk(32'(reqs - r0), 32'h0, "mode 3 used bus");
    chk(32'(tx_valid), 32'h0, "mode 3 answered");
    $display("refusal test done");
  endtask : t_refuse
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    rpt_load = 1'b0;
    rpt_value = 8'h00;
    repeat (3) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    t_ctrl();
    t_dwrite();
    t_dread();
    t_pwrite();
    t_pread();
    t_refuse();
    print_verdict();
  end
endmodule : test_debug_link_memory_access
